// >>> logic/pwm_params.svh
// register map, field positions, reset values and counts of the pwm block
// How it works
// R1: period is (period_limit + 1) times 4 system clocks times the prescale ratio
// R2: count equal to period_limit clears on the next timer increment
// R3: rollover drives the output high unless the new duty value is zero
// R4: rollover copies the duty register pair into the 10-bit duty buffer
// R5: duty writes land any time but act only after the next rollover
// R6: duty_align_select chooses how the two duty bytes form the value
// R7: time base is the count plus clock phase or two prescaler bits
// R8: time base equal to buffered duty drives the output low
// R9: high time is duty times one system clock times prescale ratio
// R10: duty beyond the period never matches, so the output stays high
// R11: no postscaler exists, so only period_limit and the prescaler shape the period
// R12: full 10-bit resolution only when period_limit is 255
// R13: sleep freezes count, prescaler and output logic and holds the output level; bus access goes on
// R14: reset restores every register and turns the pin into an input
// R15: software must pick the instruction clock as the timer clock
// R16: software sets up limit, mode, duty, flag, prescale, then timer on
// R17: software may wait for timer_match_flag before enabling the driver
// R18: align 1 is left: low duty bits sit in duty_low_byte bits 7:6
// R19: align 0 is right: duty_low_byte holds the eight low duty bits
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

`define OFS_MODULE_CONTROL   6'h00
`define OFS_DUTY_LOW_BYTE    6'h04
`define OFS_DUTY_HIGH_BYTE   6'h08
`define OFS_PERIOD_LIMIT     6'h0c
`define OFS_PERIOD_COUNT     6'h10
`define OFS_TIMER_CONTROL    6'h14
`define OFS_TIMER_CLOCK_SEL  6'h18
`define OFS_IRQ_STATUS       6'h1c
`define OFS_IRQ_MASK         6'h20
`define OFS_PIN_DIRECTION    6'h24
`define OFS_DUTY_BUFFER      6'h28

`define CTL_EN_BIT           7
`define CTL_OUT_BIT          5
`define CTL_ALIGN_BIT        4
`define TCON_ON_BIT          7
`define TCON_PRESCALE_LSB    4
`define IRQ_TIMER_MATCH_BIT  0
`define IRQ_DUTY_MATCH_BIT   1
`define IRQ_COUNT            2

`define MODE_PWM_TOP         2'h3
`define TCLK_INSTR           4'h1
`define PERIOD_LIMIT_RST     8'hff
`define DUTY_RST             8'h00
`define PIN_DIR_RST          1'b1
`define INSTR_DIV            4
`define PHASE_BITS           2
`define RDATA_ZERO           32'h0000_0000

`endif

// >>> logic/pwm_pkg.sv
// types shared by the pwm block
package pwm_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	typedef struct packed {
		logic            en;
		logic            align;
		logic [3:0]      mode;
		logic [7:0]      duty_lo;
		logic [7:0]      duty_hi;
		logic [7:0]      period_limit;
		logic [7:0]      count;
		logic            tmr_on;
		logic [1:0]      prescale_sel;
		logic [3:0]      clk_sel;
		logic [1:0]      irq_mask;
		logic            pin_dir;
		logic [9:0]      duty_buf;
		logic            out;
		logic            pend;
		bus_state_t      bus;
		logic [31:0]     rdata;
	} pwm_state_t;

endpackage

// >>> logic/pwm_prescaler.sv
// timer prescaler: increment strobe and the two low time-base bits
`timescale 1ns/1ps
`include "pwm_params.svh"
module pwm_prescaler #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             nrst_i,
	// control
	input  wire logic             run_i,
	input  wire logic             clear_i,
	input  wire logic [1:0]       prescale_sel_i,
	// time base
	output logic                  tick_o,
	output logic [1:0]            low_bits_o
);
	typedef struct packed {
		logic [CNT_W-1:0] sub;
	} presc_state_t;

	presc_state_t st_r;
	presc_state_t st_nxt;
	logic [CNT_W-1:0] top;
	int unsigned shift;

	generate
		if (CNT_W < `PHASE_BITS + 6) begin : g_bad_width
			$error("pwm_prescaler: CNT_W too small for 1:64");
		end
	endgenerate

	// ratio 4^sel: 1,4,16,64 instruction cycles per increment
	assign shift = 32'(2 * prescale_sel_i);
	assign top = {CNT_W{1'b1}} >> (CNT_W - `PHASE_BITS - shift); // see R1
	assign tick_o = run_i && !clear_i && (st_r.sub == top);
	assign low_bits_o = 2'(st_r.sub >> shift); // see R7

	always_comb begin
		st_nxt = st_r;
		if (clear_i) begin
			st_nxt.sub = '0;
		end else if (run_i) begin // see R13
			st_nxt.sub = (st_r.sub == top) ? '0 : CNT_W'(st_r.sub + 1'b1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // pwm_prescaler

// >>> logic/pwm_irq.sv
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
module pwm_irq #(
	parameter int N = 2
) (
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	// events and clears
	input  wire logic [N-1:0] set_i,
	input  wire logic [N-1:0] clr_i,
	input  wire logic [N-1:0] mask_i,
	// status
	output logic [N-1:0]      status_o,
	output logic              irq_o
);
	typedef struct packed {
		logic [N-1:0] status;
	} irq_state_t;

	irq_state_t st_r;
	irq_state_t st_nxt;

	generate
		if (N < 1) begin : g_bad_n
			$error("pwm_irq: N must be at least 1");
		end
	endgenerate

	assign status_o = st_r.status;
	assign irq_o = |(st_r.status & mask_i);

	// a new event wins over a clear in the same cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.status = (st_r.status & ~clr_i) | set_i;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // pwm_irq

// >>> logic/ten_bit_pwm.sv
// ten-bit standard pwm with period timer and avalon-mm registers
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_params.svh"
module ten_bit_pwm
	import pwm_pkg::*;
#(
	parameter int PRESC_W = 8
) (
	// clock, reset and power state
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        sleep_i,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// pwm pin
	output logic             pwm_o,
	output logic             pwm_oe_n_o,
	// interrupt
	output logic             irq_o
);
	localparam pwm_state_t RST = '{
		en:           1'b0,
		align:        1'b0,
		mode:         4'h0,
		duty_lo:      `DUTY_RST,
		duty_hi:      `DUTY_RST,
		period_limit: `PERIOD_LIMIT_RST,
		count:        8'h00,
		tmr_on:       1'b0,
		prescale_sel: 2'h0,
		clk_sel:      4'h0,
		irq_mask:     2'h0,
		pin_dir:      `PIN_DIR_RST,
		duty_buf:     10'h000,
		out:          1'b0,
		pend:         1'b0,
		bus:          BUS_IDLE,
		rdata:        `RDATA_ZERO
	};

	pwm_state_t st_r;
	pwm_state_t st_nxt;

	logic                   tick;
	logic [1:0]             low_bits;
	logic                   presc_run;
	logic                   presc_clear;
	logic [9:0]             time_base;
	logic [9:0]             duty_value;
	logic                   pwm_mode;
	logic                   rollover;
	logic                   duty_hit;
	logic [`IRQ_COUNT-1:0]  irq_set;
	logic [`IRQ_COUNT-1:0]  irq_clr;
	logic [`IRQ_COUNT-1:0]  irq_status;
	logic                   bus_req;
	logic                   bus_commit;
	logic                   wr_lane0;

	// right: high bits 1:0 over the low byte; left: high byte over bits 7:6
	function automatic logic [9:0] duty_decode(
		input logic       align,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		duty_decode = align ? {hi, lo[7:6]} : {hi[1:0], lo}; // see R6 R18 R19
	endfunction

	function automatic logic is_pwm_mode(
		input logic       en,
		input logic [3:0] mode
	);
		is_pwm_mode = en && (mode[3:2] == `MODE_PWM_TOP);
	endfunction

	// the timer only advances on the instruction clock
	assign presc_run = st_r.tmr_on && !sleep_i
		&& (st_r.clk_sel == `TCLK_INSTR); // see R15 R13
	assign presc_clear = !st_r.tmr_on;

	pwm_prescaler #(
		.CNT_W (PRESC_W)
	) u_prescaler (
		.sys_clk_i      (sys_clk_i),
		.nrst_i         (nrst_i),
		.run_i          (presc_run),
		.clear_i        (presc_clear),
		.prescale_sel_i (st_r.prescale_sel),
		.tick_o         (tick),
		.low_bits_o     (low_bits)
	);

	assign time_base = {st_r.count, low_bits}; // see R7 R12
	assign duty_value = duty_decode(st_r.align, st_r.duty_hi, st_r.duty_lo);
	assign pwm_mode = is_pwm_mode(st_r.en, st_r.mode);
	assign rollover = tick && (st_r.count == st_r.period_limit); // see R2
	assign duty_hit = pwm_mode && !sleep_i
		&& (time_base == st_r.duty_buf); // see R8

	assign bus_req = avs_read_i || avs_write_i;
	assign bus_commit = bus_req && (st_r.bus == BUS_ACK);
	assign wr_lane0 = avs_write_i && avs_byteenable_i[0];

	always_comb begin
		irq_set = '0;
		irq_set[`IRQ_TIMER_MATCH_BIT] = rollover;
		irq_set[`IRQ_DUTY_MATCH_BIT] = duty_hit && st_r.out;
	end

	// a status read clears only the bits that were returned
	assign irq_clr = (bus_commit && avs_read_i
		&& avs_address_i == `OFS_IRQ_STATUS)
		? st_r.rdata[`IRQ_COUNT-1:0] : '0;

	pwm_irq #(
		.N (`IRQ_COUNT)
	) u_irq (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.set_i     (irq_set),
		.clr_i     (irq_clr),
		.mask_i    (st_r.irq_mask),
		.status_o  (irq_status),
		.irq_o     (irq_o)
	);

	always_comb begin
		logic [31:0] rv;
		rv = `RDATA_ZERO;
		st_nxt = st_r;

		// period timer and output latch
		if (tick) begin
			if (rollover) begin
				st_nxt.count = 8'h00; // see R2 R1
				st_nxt.duty_buf = duty_value; // see R4 R5
				st_nxt.pend = pwm_mode;
			end else begin
				st_nxt.count = 8'(st_r.count + 8'h01);
			end
		end
		// set and clear both land one clock late, so high time is exact
		if (st_r.pend && !sleep_i) begin
			st_nxt.pend = 1'b0;
			st_nxt.out = pwm_mode && (st_r.duty_buf != 10'h000); // see R3
		end
		// duty past the period never matches and leaves the level alone
		if (duty_hit) begin
			st_nxt.out = 1'b0; // see R8 R9 R10
		end
		if (!pwm_mode && !sleep_i) begin
			st_nxt.out = 1'b0;
		end

		// register read mux
		unique case (avs_address_i)
			`OFS_MODULE_CONTROL: begin
				rv[`CTL_EN_BIT] = st_r.en;
				rv[`CTL_OUT_BIT] = st_r.out;
				rv[`CTL_ALIGN_BIT] = st_r.align;
				rv[3:0] = st_r.mode;
			end
			`OFS_DUTY_LOW_BYTE: begin
				rv[7:0] = st_r.duty_lo;
			end
			`OFS_DUTY_HIGH_BYTE: begin
				rv[7:0] = st_r.duty_hi;
			end
			`OFS_PERIOD_LIMIT: begin
				rv[7:0] = st_r.period_limit;
			end
			`OFS_PERIOD_COUNT: begin
				rv[7:0] = st_r.count;
			end
			`OFS_TIMER_CONTROL: begin
				rv[`TCON_ON_BIT] = st_r.tmr_on;
				rv[`TCON_PRESCALE_LSB +: 2] = st_r.prescale_sel;
			end
			`OFS_TIMER_CLOCK_SEL: begin
				rv[3:0] = st_r.clk_sel;
			end
			`OFS_IRQ_STATUS: begin
				rv[`IRQ_COUNT-1:0] = irq_status;
			end
			`OFS_IRQ_MASK: begin
				rv[`IRQ_COUNT-1:0] = st_r.irq_mask;
			end
			`OFS_PIN_DIRECTION: begin
				rv[0] = st_r.pin_dir;
			end
			`OFS_DUTY_BUFFER: begin
				rv[9:0] = st_r.duty_buf;
			end
			default: begin
				rv = `RDATA_ZERO;
			end
		endcase

		// bus handshake: one wait state, then the access commits
		unique case (st_r.bus)
			BUS_IDLE: begin
				if (bus_req) begin
					st_nxt.bus = BUS_ACK;
					st_nxt.rdata = avs_read_i ? rv : `RDATA_ZERO;
				end
			end
			BUS_ACK: begin
				st_nxt.bus = BUS_IDLE;
			end
			default: begin
				st_nxt.bus = BUS_IDLE;
			end
		endcase

		// register writes; a count write overrides the timer step
		if (bus_commit && wr_lane0) begin
			unique case (avs_address_i)
				`OFS_MODULE_CONTROL: begin
					st_nxt.en = avs_writedata_i[`CTL_EN_BIT];
					st_nxt.align = avs_writedata_i[`CTL_ALIGN_BIT];
					st_nxt.mode = avs_writedata_i[3:0];
				end
				`OFS_DUTY_LOW_BYTE: begin
					st_nxt.duty_lo = avs_writedata_i[7:0]; // see R5
				end
				`OFS_DUTY_HIGH_BYTE: begin
					st_nxt.duty_hi = avs_writedata_i[7:0]; // see R5
				end
				`OFS_PERIOD_LIMIT: begin
					st_nxt.period_limit = avs_writedata_i[7:0];
				end
				`OFS_PERIOD_COUNT: begin
					st_nxt.count = avs_writedata_i[7:0];
				end
				`OFS_TIMER_CONTROL: begin
					st_nxt.tmr_on = avs_writedata_i[`TCON_ON_BIT];
					st_nxt.prescale_sel =
						avs_writedata_i[`TCON_PRESCALE_LSB +: 2]; // see R11
				end
				`OFS_TIMER_CLOCK_SEL: begin
					st_nxt.clk_sel = avs_writedata_i[3:0];
				end
				`OFS_IRQ_MASK: begin
					st_nxt.irq_mask = avs_writedata_i[`IRQ_COUNT-1:0];
				end
				`OFS_PIN_DIRECTION: begin
					st_nxt.pin_dir = avs_writedata_i[0];
				end
				default: begin
					st_nxt.rdata = st_r.rdata;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= RST; // see R14
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_waitrequest_o = bus_req && (st_r.bus != BUS_ACK);
	assign avs_readdata_o = st_r.rdata;
	assign pwm_o = st_r.out; // see R13
	assign pwm_oe_n_o = st_r.pin_dir; // see R14 R17
endmodule // ten_bit_pwm

// >>> dv/pwm_monitor.sv
// port checker of the pwm block
`timescale 1ns/1ps
module pwm_monitor (
	// clock, reset, power
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic sleep_i,
	// bus
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// pin and interrupt
	input wire logic pwm_o,
	input wire logic pwm_oe_n_o,
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_done;
		(avs_read_i || avs_write_i) && !avs_waitrequest_o;
	endsequence
	a_wait_one_cycle: assert property (s_take |=> s_done)
		else $error("no answer after one wait");
	a_wait_after_done: assert property (s_done |=>
		!(avs_read_i || avs_write_i) || avs_waitrequest_o)
		else $error("answer without wait");
	a_wait_idle_low: assert property (!avs_read_i && !avs_write_i
		|-> !avs_waitrequest_o) else $error("wait while idle");
	a_reset_pin_safe: assert property (disable iff (1'b0)
		!nrst_i |-> pwm_oe_n_o && !pwm_o && !irq_o)
		else $error("pin driven in reset");
	a_sleep_out_held: assert property (sleep_i |=> $stable(pwm_o))
		else $error("output moved in sleep");
	a_sleep_irq_held: assert property ($rose(irq_o) |->
		$past(!sleep_i || (avs_write_i && !avs_waitrequest_o)))
		else $error("event in sleep");
	a_pin_dir_write: assert property ($changed(pwm_oe_n_o) |->
		$past(avs_write_i && !avs_waitrequest_o))
		else $error("direction moved alone");
	a_irq_clear_bus: assert property ($fell(irq_o) |->
		$past((avs_read_i || avs_write_i) && !avs_waitrequest_o))
		else $error("interrupt dropped alone");
endmodule // pwm_monitor
bind ten_bit_pwm pwm_monitor u_mon (.sys_clk_i, .nrst_i, .sleep_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .pwm_o,
	.pwm_oe_n_o, .irq_o);

// >>> dv/pwm_load.sv
// load on the pwm pin, measures period and high time
`timescale 1ns/1ps
module pwm_load (
	// clock
	input wire logic sys_clk_i,
	// pin
	input wire logic pwm_o,
	input wire logic pwm_oe_n_o,
	// measurements
	output int       per_len_o,
	output int       hi_len_o
);
	int   cnt = 0;
	logic last = 1'b0;
	// released pin falls to the pull-down level
	wire  pin = pwm_oe_n_o ? 1'b0 : pwm_o;
	always @(posedge sys_clk_i) begin
		cnt <= cnt + 1;
		last <= pin;
		if (pin && !last) begin
			per_len_o <= cnt;
			cnt <= 1;
		end
		if (!pin && last)
			hi_len_o <= cnt;
	end
endmodule // pwm_load

// >>> dv/tb_ten_bit_pwm.sv
// self-checking bench of the ten-bit pwm block
`timescale 1ns/1ps
`include "pwm_params.svh"
module tb_ten_bit_pwm;
	logic        sys_clk_i = 1'b0;
	logic        nrst_i = 1'b1;
	logic        sleep_i = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat, r;
	logic [7:0]  lm;
	logic        wrq, pwm, oe_n, irq, p0;
	wire         pin = oe_n ? 1'b0 : pwm;
	int          per_len, hi_len, c0;
	int          mismatches = 0;
	int          compares = 0;
	logic [5:0]  ra [5] = '{`OFS_MODULE_CONTROL, `OFS_PERIOD_LIMIT,
		`OFS_PIN_DIRECTION, `OFS_DUTY_BUFFER, 6'h3c};
	logic [7:0]  rv [5] = '{8'h00, 8'hff, 8'h01, 8'h00, 8'h00};
	always #25 sys_clk_i = ~sys_clk_i;
	ten_bit_pwm uut (.sys_clk_i, .nrst_i, .sleep_i, .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wrq), .pwm_o(pwm), .pwm_oe_n_o(oe_n),
		.irq_o(irq));
	pwm_load load (.sys_clk_i, .pwm_o(pwm), .pwm_oe_n_o(oe_n),
		.per_len_o(per_len), .hi_len_o(hi_len));
	task automatic wrap_up();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic stuck();
		mismatches++;
		$display("CHECK FAILED %0t timeout", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		int n;
		@(posedge sys_clk_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wrq !== 1'b0 && n < 9);
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 9) stuck();
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (irq !== 1'b1 && n < 20000);
		if (n == 20000) stuck();
	endtask
	function automatic int exp_hi(int du, int lim, int ps);
		int per;
		per = (lim + 1) * 4 << (2 * ps);
		return du << (2 * ps) > per ? per : du << (2 * ps);
	endfunction
	task automatic run_case(input logic al, input logic [9:0] du,
		input logic [7:0] lim, input logic [1:0] ps);
		int per, hi, n;
		logic [7:0] h, l;
		per = (lim + 1) * 4 << (2 * ps);
		r = $urandom;
		h = al ? du[9:2] : {r[5:0], du[9:8]};
		l = al ? {du[1:0], r[11:6]} : du[7:0];
		bus(1, `OFS_PERIOD_LIMIT, lim);
		bus(1, `OFS_PERIOD_COUNT, 8'h00);
		bus(1, `OFS_MODULE_CONTROL, {3'b100, al, 4'hc});
		bus(1, `OFS_DUTY_HIGH_BYTE, h);
		bus(1, `OFS_DUTY_LOW_BYTE, l);
		bus(0, `OFS_IRQ_STATUS, 8'h00);
		bus(1, `OFS_TIMER_CONTROL, {2'b10, ps, 4'h0});
		wait_irq();
		bus(0, `OFS_DUTY_BUFFER, 8'h00);
		chk(r, {22'h00_0000, du});
		bus(0, `OFS_IRQ_STATUS, 8'h00);
		wait_irq();
		hi = 0;
		for (n = 0; n < per; n++) begin
			hi += int'(pin);
			@(negedge sys_clk_i);
		end
		chk(hi, exp_hi(du, lim, ps));
		if (hi > 0 && hi < per) begin
			@(negedge sys_clk_i);
			chk(per_len, per);
			chk(hi_len, hi);
		end
	endtask
	initial begin
		nrst_i <= 1'b0;
		void'($urandom(32'h0000_03c7));
		repeat (8) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		bus(1, `OFS_DUTY_BUFFER, 8'hff);
		foreach (ra[i]) begin
			bus(0, ra[i], 8'h00);
			chk(r, {24'h00_0000, rv[i]});
		end
		bus(1, `OFS_TIMER_CLOCK_SEL, 8'h01);
		bus(1, `OFS_PERIOD_LIMIT, 8'h01);
		bus(1, `OFS_TIMER_CONTROL, 8'h80);
		repeat (20) @(negedge sys_clk_i);
		chk(irq, 1'b0);
		bus(1, `OFS_IRQ_MASK, 8'h01);
		@(negedge sys_clk_i);
		chk(irq, 1'b1);
		bus(1, `OFS_TIMER_CONTROL, 8'h00);
		bus(0, `OFS_IRQ_STATUS, 8'h00);
		chk(r[0], 1'b1);
		@(negedge sys_clk_i);
		chk(irq, 1'b0);
		bus(1, `OFS_PIN_DIRECTION, 8'h00);
		run_case(0, 10'h000, 8'h03, 2'h0);
		run_case(1, 10'h3ff, 8'h03, 2'h0);
		run_case(0, 10'h3fe, 8'hff, 2'h0);
		run_case(1, 10'h025, 8'h07, 2'h1);
		repeat (6) begin
			lm = 8'($urandom_range(7, 1));
			run_case(1'($urandom), 10'($urandom_range(4 * lm + 6)), lm,
				2'($urandom_range(2)));
		end
		@(posedge sys_clk_i);
		sleep_i <= 1'b1;
		@(negedge sys_clk_i);
		p0 = pin;
		bus(0, `OFS_PERIOD_COUNT, 8'h00);
		c0 = r;
		repeat (30) @(negedge sys_clk_i);
		chk(pin, p0);
		bus(0, `OFS_PERIOD_COUNT, 8'h00);
		chk(r, c0);
		sleep_i <= 1'b0;
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({oe_n, pwm}, 2'b10);
		repeat (8) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		bus(0, `OFS_PERIOD_LIMIT, 8'h00);
		chk(r, 32'h0000_00ff);
		wrap_up();
	end
endmodule // tb_ten_bit_pwm
